// ### bsp_defs.svh
// Constants for the bitstream engine: register map, field positions, counts.
// Assumes inclusion by bare name from each design file.
`ifndef BSP_DEFS_SVH
`define BSP_DEFS_SVH
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define GPR_N 8
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_REF_LO 8'h08
`define ADDR_REF_HI 8'h0c
`define ADDR_MASK_LO 8'h10
`define ADDR_MASK_HI 8'h14
`define ADDR_PAGE 8'h18
`define CTRL_ENCODE 0
`define CTRL_PRIME 1
`define ST_CNT_LSB 0
`define ST_VB_LSB 5
`define ST_ENCODE 11
`define ST_STALL 12
`define ST_ENC_BUSY 13
`define ST_MATCH 14
`define MAX_GET 4'd8
`define VLC_BITS 4'd4
`define ENC_PIPE_CYCLES 4'd8
`define FULL_BITS 6'd32
`endif

// ### bsp_pkg.sv
// Types shared by the bitstream engine files.
// Assumes nothing beyond a SystemVerilog compiler.
package bsp_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_VLC = 3'b001,
    ST_REFILL = 3'b010,
    ST_PRIME_A = 3'b011,
    ST_PRIME_B = 3'b100
  } state_e;
  typedef enum logic [4:0] {
    OP_NOP = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_AND = 5'h03,
    OP_OR = 5'h04, OP_ADDI = 5'h05, OP_NEG = 5'h06, OP_ABS = 5'h07,
    OP_SCAN = 5'h08, OP_MUL = 5'h09, OP_LD = 5'h0a, OP_ST = 5'h0b,
    OP_LDA = 5'h0c, OP_STA = 5'h0d, OP_GETB = 5'h0e, OP_SRCH = 5'h0f,
    OP_SETPG = 5'h10, OP_PUTW = 5'h11, OP_CPH = 5'h12, OP_VLCS = 5'h13
  } opcode_e;
endpackage

// ### bitstream_fifo.sv
// Sixteen-word by 32-bit bitstream FIFO with valid/ready on both sides.
// Assumes one clock; the parent steers which party fills and which drains.
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"
module bitstream_fifo (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [31:0] out_data,
  input wire logic out_ready,
  output logic [`FIFO_AW:0] count
);
  logic [31:0] mem_q [`FIFO_DEPTH];
  logic [`FIFO_AW-1:0] wp_q, rp_q;
  logic [`FIFO_AW:0] cnt_q;
  logic push, pop;

  assign in_ready = cnt_q != (`FIFO_AW+1)'(`FIFO_DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rp_q];
  assign count = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage needs no reset; pointers define what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### bitstream_engine.sv
// Bitstream engine: 16-bit core, bit shifter, code search, FIFO steering.
// Assumes an APB master, an instruction source, a halfword memory and a DMA.
//
// What the document requires
// R1: Software leaves encode resources alone eight cycles after a pack op.
// R2: Parse ops may suspend; two no-ops must follow each. Here the core stalls followers until the op ends, without no-ops.
// R3: One instruction issued and completed per clock, multi-cycle ops excepted.
// R4: Table parse takes four stream bits per two-cycle lookup-and-discard step.
// R5: Sixteen-bit load-store core with eight registers, ALU, multiplier, shifter.
// R6: Register zero is an ordinary register, not tied to zero.
// R7: Dedicated negate, absolute value and zig-zag/alternate scan translation units.
// R8: Ordinary load/store address is page base plus 8-bit immediate.
// R9: Absolute load/store use the register address directly, whole 16-bit space.
// R10: Two-cycle multiply; low half to a register, high to compare upper half.
// R11: Scan translator maps low six bits, zero-extended result to a register.
// R12: FIFO of sixteen 32-bit words; in decode DMA fills, core drains words.
// R13: In encode the core fills the FIFO and DMA drains it.
// R14: Shifter is 32-bit head, 32-bit refill and 64-bit shift; words enter refill.
// R15: Stream kept left-justified; reads come from head's top eight bits.
// R16: Request for up to eight bits returns them right-justified, zero-filled.
// R17: After N bits, head and refill shift left together by N.
// R18: With at least N valid refill bits the shift takes one step.
// R19: Otherwise refill from FIFO, shift N minus old count, count becomes 32-(N-old).
// R20: Core stalls during the refill-and-shift until the fetch ends.
// R21: Code search compares head bits to reference under mask, one to 32 bits.
// R22: Reference and mask are 32 bits, each two separately written halves.
// R23: Software must not write a register in the slot after a multiply.
// R24: Refill on empty FIFO stalls until DMA supplies a word, then completes.
`timescale 1ns/1ps
`default_nettype none
`include "bsp_defs.svh"
module bitstream_engine
  import bsp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  output logic instr_ready,
  output logic mem_rd,
  output logic [15:0] mem_raddr,
  input wire logic [15:0] mem_rdata,
  output logic mem_wr,
  output logic [15:0] mem_waddr,
  output logic [15:0] mem_wdata,
  input wire logic dma_fill_valid,
  input wire logic [31:0] dma_fill_data,
  output logic dma_fill_ready,
  output logic dma_drain_valid,
  output logic [31:0] dma_drain_data,
  input wire logic dma_drain_ready
);
  // ----------------------------------------
  // Scan tables, indexed by scan position
  // ----------------------------------------
  localparam logic [5:0] ZZ_TAB [64] = '{
    0, 1, 8, 16, 9, 2, 3, 10, 17, 24, 32, 25, 18, 11, 4, 5,
    12, 19, 26, 33, 40, 48, 41, 34, 27, 20, 13, 6, 7, 14, 21, 28,
    35, 42, 49, 56, 57, 50, 43, 36, 29, 22, 15, 23, 30, 37, 44, 51,
    58, 59, 52, 45, 38, 31, 39, 46, 53, 60, 61, 54, 47, 55, 62, 63};
  localparam logic [5:0] ALT_TAB [64] = '{
    0, 8, 16, 24, 1, 9, 2, 10, 17, 25, 32, 40, 48, 56, 57, 49,
    41, 33, 26, 18, 3, 11, 4, 12, 19, 27, 34, 42, 50, 58, 35, 43,
    51, 59, 20, 28, 5, 13, 6, 14, 21, 29, 36, 44, 52, 60, 37, 45,
    53, 61, 22, 30, 7, 15, 23, 31, 38, 46, 54, 62, 39, 47, 55, 63};

  function automatic logic addr_ok(input logic [7:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'b00};
    addr_ok = (w == `ADDR_CTRL) || (w == `ADDR_STATUS) || (w == `ADDR_REF_LO) ||
              (w == `ADDR_REF_HI) || (w == `ADDR_MASK_LO) || (w == `ADDR_MASK_HI) ||
              (w == `ADDR_PAGE);
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  state_e state_q;
  logic [15:0] gpr_q [`GPR_N];
  logic [15:0] page_q, cmp_hi_q, mul_lo_q, mul_hi_q;
  logic [2:0] mul_rd_q;
  logic mul_pend_q;
  logic [31:0] ref_q, mask_q, alpha_q, beta_q, prdata_q;
  logic [5:0] vbits_q;
  logic [3:0] pend_n_q, enc_cnt_q;
  logic encode_q, prime_q, match_q, pslverr_q;
  logic mem_wr_q;
  logic [15:0] mem_waddr_q, mem_wdata_q;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  opcode_e op;
  logic [2:0] rd, rs, rt;
  logic [7:0] imm8;
  logic [15:0] a, b, d, page_ea, head_bits, wb_val;
  logic [3:0] n_req;
  logic issue, wb_en, hit, stall;
  logic [31:0] prod;

  assign op = opcode_e'(instr[15:11]);
  assign rd = instr[10:8];
  assign rs = instr[7:5];
  assign rt = instr[4:2];
  assign imm8 = instr[7:0];
  assign a = gpr_q[rs];
  assign b = gpr_q[rt];
  assign d = gpr_q[rd];
  assign n_req = (instr[3:0] > `MAX_GET) ? `MAX_GET : instr[3:0];
  assign page_ea = page_q + {8'h00, imm8}; // R8
  assign head_bits = 16'({8'h00, alpha_q[31:24]} >> (`MAX_GET - n_req)); // R15 R16
  assign hit = ((alpha_q ^ ref_q) & mask_q) == 32'h0000_0000; // R21
  assign prod = a * b;

  // ----------------------------------------
  // FIFO steering
  // ----------------------------------------
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  logic [31:0] f_in_data, f_out_data;
  logic [`FIFO_AW:0] f_count;
  logic push_valid, pop_ready, pop_valid, pop;

  assign push_valid = issue && op == OP_PUTW && encode_q;
  assign f_in_valid = encode_q ? push_valid : dma_fill_valid; // R12 R13
  assign f_in_data = encode_q ? {a, b} : dma_fill_data;
  assign dma_fill_ready = !encode_q && f_in_ready;
  assign f_out_ready = encode_q ? dma_drain_ready : pop_ready;
  assign dma_drain_valid = encode_q && f_out_valid; // R13
  assign dma_drain_data = f_out_data;
  assign pop_valid = !encode_q && f_out_valid;
  assign pop_ready = !encode_q && (state_q == ST_REFILL || state_q == ST_PRIME_A ||
                                   state_q == ST_PRIME_B);
  assign pop = pop_ready && pop_valid;

  bitstream_fifo u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(f_out_valid),
    .out_data(f_out_data),
    .out_ready(f_out_ready),
    .count(f_count)
  );

  // ----------------------------------------
  // Issue and stall
  // ----------------------------------------
  // Suspended multi-cycle ops hold the slot, so followers wait
  assign stall = state_q != ST_RUN || prime_q; // R2 R20 R24
  assign instr_ready = !stall && !(op == OP_PUTW && encode_q && !f_in_ready); // R3
  assign issue = instr_valid && instr_ready;

  // ----------------------------------------
  // Register write-back
  // ----------------------------------------
  always_comb begin
    wb_en = issue;
    wb_val = 16'h0000;
    case (op)
      OP_ADD: wb_val = a + b; // R5
      OP_SUB: wb_val = a - b;
      OP_AND: wb_val = a & b;
      OP_OR: wb_val = a | b;
      OP_ADDI: wb_val = d + {8'h00, imm8};
      OP_NEG: wb_val = -a; // R7
      OP_ABS: wb_val = a[15] ? -a : a; // R7
      OP_SCAN: wb_val = {10'h000, instr[0] ? ALT_TAB[a[5:0]] : ZZ_TAB[a[5:0]]}; // R11
      OP_LD, OP_LDA, OP_VLCS: wb_val = mem_rdata;
      OP_GETB: wb_val = head_bits; // R16
      OP_SRCH: wb_val = {15'h0000, hit};
      OP_CPH: wb_val = cmp_hi_q;
      default: wb_en = 1'b0;
    endcase
  end

  // Every register, zero included, is fully writable
  for (genvar g = 0; g < `GPR_N; g++) begin : g_gpr
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        gpr_q[g] <= 16'h0000;
      end else if (mul_pend_q && mul_rd_q == 3'(g)) begin
        gpr_q[g] <= mul_lo_q; // R10
      end else if (wb_en && rd == 3'(g)) begin
        gpr_q[g] <= wb_val; // R6
      end
    end
  end

  // Product lands one cycle after issue; the slot in between stays open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mul_pend_q <= 1'b0;
      mul_rd_q <= 3'h0;
      mul_lo_q <= 16'h0000;
      mul_hi_q <= 16'h0000;
      cmp_hi_q <= 16'h0000;
    end else begin
      mul_pend_q <= issue && op == OP_MUL; // R10 R23
      if (issue && op == OP_MUL) begin
        mul_rd_q <= rd;
        mul_lo_q <= prod[15:0];
        mul_hi_q <= prod[31:16];
      end
      if (mul_pend_q) begin
        cmp_hi_q <= mul_hi_q; // R10
      end
    end
  end

  // ----------------------------------------
  // Memory port
  // ----------------------------------------
  always_comb begin
    mem_rd = issue && (op == OP_LD || op == OP_LDA || op == OP_VLCS);
    case (op)
      OP_LD: mem_raddr = page_ea; // R8
      OP_VLCS: mem_raddr = a + {12'h000, alpha_q[31:28]}; // R4
      default: mem_raddr = a; // R9
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_wr_q <= 1'b0;
      mem_waddr_q <= 16'h0000;
      mem_wdata_q <= 16'h0000;
      page_q <= 16'h0000;
    end else begin
      mem_wr_q <= issue && (op == OP_ST || op == OP_STA);
      mem_waddr_q <= (op == OP_ST) ? page_ea : a; // R8 R9
      mem_wdata_q <= d;
      if (issue && op == OP_SETPG) begin
        page_q <= a;
      end
    end
  end

  assign mem_wr = mem_wr_q;
  assign mem_waddr = mem_waddr_q;
  assign mem_wdata = mem_wdata_q;

  // ----------------------------------------
  // Shifter sequencing
  // ----------------------------------------
  logic sh_now, need_refill;
  logic [3:0] sh_n;
  logic [63:0] t_old, t_new;

  assign sh_n = (state_q == ST_VLC) ? `VLC_BITS : n_req;
  assign sh_now = (issue && op == OP_GETB && vbits_q >= {2'b00, n_req}) ||
                  (state_q == ST_VLC && vbits_q >= {2'b00, `VLC_BITS}); // R18
  assign need_refill = (issue && op == OP_GETB && vbits_q < {2'b00, n_req}) ||
                       (state_q == ST_VLC && vbits_q < {2'b00, `VLC_BITS});
  // Old refill bits first join the head, then the new word is shifted
  assign t_old = {alpha_q, beta_q} << vbits_q;
  assign t_new = {t_old[63:32], f_out_data} << ({2'b00, pend_n_q} - vbits_q); // R19

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RUN;
      pend_n_q <= 4'h0;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (prime_q) begin
            state_q <= ST_PRIME_A;
          end else if (need_refill) begin
            state_q <= ST_REFILL; // R20
            pend_n_q <= n_req;
          end else if (issue && op == OP_VLCS) begin
            state_q <= ST_VLC; // R4
          end
        end
        ST_VLC: begin
          state_q <= need_refill ? ST_REFILL : ST_RUN; // R4
          pend_n_q <= `VLC_BITS;
        end
        ST_REFILL: if (pop) state_q <= ST_RUN; // R24
        ST_PRIME_A: if (pop) state_q <= ST_PRIME_B;
        ST_PRIME_B: if (pop) state_q <= ST_RUN;
        default: state_q <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alpha_q <= 32'h0000_0000;
      beta_q <= 32'h0000_0000;
      vbits_q <= 6'h00;
    end else if (sh_now) begin
      {alpha_q, beta_q} <= {alpha_q, beta_q} << sh_n; // R17
      vbits_q <= vbits_q - {2'b00, sh_n};
    end else if (state_q == ST_REFILL && pop) begin
      {alpha_q, beta_q} <= t_new; // R14 R19
      vbits_q <= `FULL_BITS - ({2'b00, pend_n_q} - vbits_q); // R19
    end else if (state_q == ST_PRIME_A && pop) begin
      alpha_q <= f_out_data;
    end else if (state_q == ST_PRIME_B && pop) begin
      beta_q <= f_out_data; // R14
      vbits_q <= `FULL_BITS;
    end
  end

  // ----------------------------------------
  // Search and encode-pipe status
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= 1'b0;
      enc_cnt_q <= 4'h0;
    end else begin
      if (issue && op == OP_SRCH) begin
        match_q <= hit; // R21
      end
      // Busy flag only informs software; nothing is blocked by it
      if (push_valid && f_in_ready) begin
        enc_cnt_q <= `ENC_PIPE_CYCLES; // R1
      end else if (enc_cnt_q != 4'h0) begin
        enc_cnt_q <= enc_cnt_q - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic setup, wr_acc;
  logic [7:0] wa;
  logic [31:0] status;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign wa = {paddr[7:2], 2'b00};
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  always_comb begin
    status = 32'h0000_0000;
    status[`ST_CNT_LSB +: 5] = f_count;
    status[`ST_VB_LSB +: 6] = vbits_q;
    status[`ST_ENCODE] = encode_q;
    status[`ST_STALL] = stall;
    status[`ST_ENC_BUSY] = enc_cnt_q != 4'h0;
    status[`ST_MATCH] = match_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !addr_ok(paddr);
      case (wa)
        `ADDR_CTRL: prdata_q <= {30'h0, prime_q, encode_q};
        `ADDR_STATUS: prdata_q <= status;
        `ADDR_REF_LO: prdata_q <= {16'h0000, ref_q[15:0]};
        `ADDR_REF_HI: prdata_q <= {16'h0000, ref_q[31:16]};
        `ADDR_MASK_LO: prdata_q <= {16'h0000, mask_q[15:0]};
        `ADDR_MASK_HI: prdata_q <= {16'h0000, mask_q[31:16]};
        `ADDR_PAGE: prdata_q <= {16'h0000, page_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      encode_q <= 1'b0;
      prime_q <= 1'b0;
      ref_q <= 32'h0000_0000;
      mask_q <= 32'h0000_0000;
    end else begin
      // A new request wins over the consumption in the same cycle
      if (wr_acc && wa == `ADDR_CTRL && pwdata[`CTRL_PRIME]) begin
        prime_q <= 1'b1;
      end else if (state_q == ST_RUN) begin
        prime_q <= 1'b0;
      end
      if (wr_acc) begin
        case (wa)
          `ADDR_CTRL: encode_q <= pwdata[`CTRL_ENCODE];
          `ADDR_REF_LO: ref_q[15:0] <= pwdata[15:0]; // R22
          `ADDR_REF_HI: ref_q[31:16] <= pwdata[15:0]; // R22
          `ADDR_MASK_LO: mask_q[15:0] <= pwdata[15:0]; // R22
          `ADDR_MASK_HI: mask_q[31:16] <= pwdata[15:0]; // R22
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### bsp_checker_props.sv
// Pin-level assertions for the bitstream engine.
// Assumes it is bound to bitstream_engine and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module bsp_checker
  import bsp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic instr_ready,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic dma_fill_valid,
  input wire logic dma_fill_ready,
  input wire logic dma_drain_valid,
  input wire logic [31:0] dma_drain_data,
  input wire logic dma_drain_ready
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic iss, is_st, is_ld;
  assign iss = instr_valid && instr_ready;
  assign is_st = iss && (instr[15:11] == OP_ST || instr[15:11] == OP_STA);
  assign is_ld = iss && (instr[15:11] == OP_LD || instr[15:11] == OP_LDA);

  chk_apb_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_unmapped_err: assert property (psel && penable |-> pslverr == (paddr[7:2] > 6'd6))
    else $error("pslverr does not follow the address map");
  chk_fifo_one_way: assert property (dma_fill_ready |-> !dma_drain_valid)
    else $error("fill and drain open together");
  chk_drain_held: assert property (dma_drain_valid && !dma_drain_ready |=> dma_drain_valid && $stable(dma_drain_data))
    else $error("drain word dropped before taken");
  chk_alu_single: assert property (iss && instr[15:11] == OP_ADDI && !(psel && penable)
    |=> instr_ready || instr[15:11] == OP_PUTW)
    else $error("core not ready after single-cycle op");
  chk_load_reads: assert property (is_ld |-> mem_rd)
    else $error("load issued without memory read");
  chk_store_pulse: assert property (is_st |=> mem_wr)
    else $error("store issued without write pulse");
  chk_write_cause: assert property (mem_wr |-> $past(is_st))
    else $error("write pulse without a store");

  cov_fill: cover property (dma_fill_valid && dma_fill_ready);
  cov_drain: cover property (dma_drain_valid && dma_drain_ready);
  cov_stall: cover property (instr_valid && !instr_ready ##1 instr_valid && instr_ready);
endmodule

bind bitstream_engine bsp_checker u_bsp_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
  .instr(instr), .instr_ready(instr_ready), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .dma_fill_valid(dma_fill_valid), .dma_fill_ready(dma_fill_ready), .dma_drain_valid(dma_drain_valid),
  .dma_drain_data(dma_drain_data), .dma_drain_ready(dma_drain_ready));
`default_nettype wire

// ### bsp_dma_model.sv
// Behavioural DMA partner: fills the FIFO from a queue, drains it with stalls.
// Assumes the bench pushes words into the queue hierarchically.
`timescale 1ns/1ps
`default_nettype none
module bsp_dma_model (
  input wire logic pclk,
  input wire logic presetn,
  output logic fill_valid,
  output logic [31:0] fill_data,
  input wire logic fill_ready,
  input wire logic drain_valid,
  input wire logic [31:0] drain_data,
  output logic drain_ready
);
  logic [31:0] words[$];

  // Released data shows the inverse of the last word, never a stale copy
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_valid <= 1'b0;
      fill_data <= 32'h0;
      drain_ready <= 1'b0;
    end else begin
      drain_ready <= 1'($urandom_range(0, 1));
      if (fill_valid && fill_ready) begin
        fill_valid <= 1'b0;
        fill_data <= ~fill_data;
      end else if (!fill_valid && words.size() > 0) begin
        fill_valid <= 1'b1;
        fill_data <= words.pop_front();
      end
    end
  end
endmodule
`default_nettype wire

// ### bitstream_processor_datapath_tb.sv
// Self-checking bench for the bitstream engine: APB, core ops, shifter, FIFO.
// Assumes bsp_pkg, the design, the checker and the DMA model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bitstream_processor_datapath_tb;
  import bsp_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, instr_valid, pready, pslverr, instr_ready;
  logic mem_rd, mem_wr, dma_fill_valid, dma_fill_ready, dma_drain_valid, dma_drain_ready;
  logic [7:0] paddr;
  logic [15:0] instr, mem_raddr, mem_rdata, mem_waddr, mem_wdata, va, vb;
  logic [31:0] pwdata, prdata, dma_fill_data, dma_drain_data, prod;
  logic [31:0] mem_q[$], enc_q[$], w[4];
  logic [32:0] apb_q[$];
  logic [127:0] strm;
  int n_errors = 0;
  int comparisons = 0;
  int pos, n;

  // Memory answers in the same cycle with an address-derived pattern
  assign mem_rdata = mem_raddr ^ 16'h5a5a;

  bitstream_engine u_bitstream_engine (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .mem_rd(mem_rd),
    .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_wr(mem_wr), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .dma_fill_valid(dma_fill_valid), .dma_fill_data(dma_fill_data),
    .dma_fill_ready(dma_fill_ready), .dma_drain_valid(dma_drain_valid), .dma_drain_data(dma_drain_data),
    .dma_drain_ready(dma_drain_ready));

  bsp_dma_model u_bsp_dma_model (.pclk(pclk), .presetn(presetn), .fill_valid(dma_fill_valid),
    .fill_data(dma_fill_data), .fill_ready(dma_fill_ready), .drain_valid(dma_drain_valid),
    .drain_data(dma_drain_data), .drain_ready(dma_drain_ready));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (apb_q.size() + mem_q.size() + enc_q.size() != 0) n_errors++;
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // Valid stays up between ops; idle drops it and lets edges pass
  task automatic op(input opcode_e o, input logic [2:0] r, input logic [7:0] lo);
    instr_valid <= 1'b1;
    instr <= {o, r, lo};
    do @(posedge pclk); while (instr_ready !== 1'b1);
  endtask

  task automatic idle(input int k);
    instr_valid <= 1'b0;
    repeat (k) @(posedge pclk);
  endtask

  task automatic st(input logic [2:0] r, input logic [7:0] a, input logic [15:0] d);
    mem_q.push_back({8'h00, a, d});
    op(OP_ST, r, a);
  endtask

  // ----------------------------------------
  // Clock, watchdog, monitor, sequence
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    tally_and_finish();
  end

  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, apb_q.size() ? apb_q.pop_front() : 'x);
    if (mem_wr) check({mem_waddr, mem_wdata}, mem_q.size() ? mem_q.pop_front() : 'x);
    if (dma_drain_valid && dma_drain_ready) check(dma_drain_data, enc_q.size() ? enc_q.pop_front() : 'x);
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    void'($urandom(29055));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 8'h04, 32'hffff_ffff);
    for (int a = 0; a < 36; a += 4) rd(8'(a), {1'(a > 24), 32'h0});
    for (int a = 8; a < 24; a += 4) begin
      va = 16'($urandom);
      apb(1'b1, 8'(a), {16'h0, va});
      rd(8'(a), {17'h0, va});
    end
    // Decode: three words in, prime, then bit reads across refills
    for (int i = 0; i < 4; i++) w[i] = $urandom;
    strm = {w[0], w[1], w[2], w[3]};
    for (int i = 0; i < 3; i++) u_bsp_dma_model.words.push_back(w[i]);
    repeat (12) @(posedge pclk);
    rd(8'h04, {28'h0, 5'd3});
    apb(1'b1, 8'h00, 32'h2);
    repeat (6) @(posedge pclk);
    rd(8'h04, {22'h0, 6'd32, 5'd1});
    // Last word arrives late so a refill finds the FIFO empty
    fork
      begin
        repeat (60) @(posedge pclk);
        u_bsp_dma_model.words.push_back(w[3]);
      end
    join_none
    pos = 0;
    while (pos < 72) begin
      n = $urandom_range(1, 8);
      op(OP_GETB, 3'd1, 8'(n));
      st(3'd1, 8'(pos), 16'(strm[127-pos -: 8] >> (8 - n)));
      pos += n;
    end
    // Table step: lookup by the top four head bits, then discard them
    op(OP_VLCS, 3'd1, 8'h00);
    st(3'd1, 8'h89, 16'(strm[127-pos -: 4]) ^ 16'h5a5a);
    pos += 4;
    idle(4);
    rd(8'h04, {22'h0, 6'((32 - pos % 32) % 32), 5'd0});
    apb(1'b1, 8'h10, 32'h0);
    apb(1'b1, 8'h14, 32'h0);
    // Core: register zero, paged load, multiply halves
    va = 16'($urandom_range(128, 255));
    op(OP_ADDI, 3'd0, va[7:0]);
    st(3'd0, 8'h80, va);
    op(OP_LD, 3'd3, 8'h81);
    st(3'd3, 8'h82, 16'h0081 ^ 16'h5a5a);
    op(OP_ADDI, 3'd2, va[7:0]);
    op(OP_ADDI, 3'd2, va[7:0]);
    prod = 4 * va * va;
    op(OP_MUL, 3'd4, 8'h48);
    op(OP_NOP, 3'd0, 8'h00);
    st(3'd4, 8'h83, prod[15:0]);
    op(OP_CPH, 3'd5, 8'h00);
    st(3'd5, 8'h84, prod[31:16]);
    // Negate, absolute value and subtract chained on 16'h5adb
    op(OP_NEG, 3'd4, 8'h60);
    op(OP_ABS, 3'd5, 8'h80);
    op(OP_SUB, 3'd5, 8'hb0);
    st(3'd5, 8'h85, 16'hb5b6);
    // Scan position 27: zig-zag gives 6, alternate gives 42
    op(OP_SCAN, 3'd2, 8'h60);
    st(3'd2, 8'h86, 16'h0006);
    op(OP_SCAN, 3'd2, 8'h61);
    st(3'd2, 8'h87, 16'h002a);
    mem_q.push_back(32'h5adb_002a);
    op(OP_STA, 3'd2, 8'h60);
    op(OP_LDA, 3'd1, 8'h60);
    st(3'd1, 8'h88, 16'h0081);
    // Mask cleared earlier, so every stream matches
    op(OP_SRCH, 3'd2, 8'h00);
    st(3'd2, 8'h8a, 16'h0001);
    idle(2);
    // Encode: core fills, DMA drains with stalls
    apb(1'b1, 8'h00, 32'h1);
    va = 16'h0;
    vb = 16'h0;
    repeat (3) begin
      pos = $urandom_range(0, 255);
      n = $urandom_range(0, 255);
      va += 16'(pos);
      vb += 16'(n);
      op(OP_ADDI, 3'd6, 8'(pos));
      op(OP_ADDI, 3'd7, 8'(n));
      enc_q.push_back({va, vb});
      op(OP_PUTW, 3'd0, 8'hdc);
      idle(8);
    end
    idle(40);
    tally_and_finish();
  end
endmodule
`default_nettype wire
